// file: design/udi_pkg.sv
// Constants, register map and types of the USB device interrupt logic.
// Assumes a 40 MHz CLK and a plain one-cycle register port.
// How it works
// R01: Pending enabled cause drives the interrupt pin to its active level.
// R02: Polarity bit 0 low gives active-low pin, high gives active-high.
// R03: After hardware or software reset the pin is active low.
// R04: Pin stays active while any enabled cause pends, no new edge.
// R05: Firmware may clear then restore the enable mask to force an edge.
// R06: Eight causes, each sets its status bit only when enabled.
// R07: Enable bit n gates status bit n; 1 enables, 0 disables.
// R08: A status bit reads 0 whenever its enable bit is 0.
// R09: Status bits 0..4: setup, EP1, EP2, EP0 receive, EP0 transmit.
// R10: Status bit 5 bus reset, bit 6 suspend, bit 7 EP3.
// R11: Eight stored setup bytes set setup-ready flag bit 0.
// R12: Enabled setup-ready sets status bit 0 same cycle, pin goes active.
// R13: Writing 1 to setup-ready clears flag, status bit and pin.
// R14: After any reset only the setup-ready cause is enabled.
// R15: SE0 held 2.5 us sets bus-reset bit 5; writing 1 clears it.
// R16: Idle 3 ms sets suspend bit 6; resume or bus reset clears it.
// R17: Pin active exactly while any status bit is 1, polarity applied.
package udi_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_CAUSES = 8;

  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h01;
  localparam logic [7:0] OFS_PIN_POLARITY_SELECT = 8'h02;
  localparam logic [7:0] OFS_EP0ST  = 8'h03;
  localparam logic [7:0] OFS_DEVST  = 8'h04;
  localparam logic [7:0] OFS_PACKET_READY_FLAGS = 8'h05;
  localparam logic [7:0] OFS_SYSCTL = 8'h06;

  localparam logic [7:0] RST_ENABLE = 8'h01;
  localparam logic       RST_POL    = 1'b0;

  localparam int unsigned BIT_SETUP  = 0;
  localparam int unsigned BIT_EP1    = 1;
  localparam int unsigned BIT_EP2    = 2;
  localparam int unsigned BIT_EP0RX  = 3;
  localparam int unsigned BIT_EP0TX  = 4;
  localparam int unsigned BIT_BUSRST = 5;
  localparam int unsigned BIT_SUSP   = 6;
  localparam int unsigned BIT_EP3    = 7;
  localparam int unsigned BIT_SWRST  = 0;
  localparam int unsigned BIT_POL    = 0;

  localparam int unsigned PR_EP0RX = 0;
  localparam int unsigned PR_EP1RX = 1;
  localparam int unsigned PR_EP2RX = 2;
  localparam int unsigned PR_EP0TX = 4;
  localparam int unsigned PR_EP1TX = 5;
  localparam int unsigned PR_EP2TX = 6;
  localparam int unsigned PR_EP3TX = 7;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SE0_MIN_NS    = 2500;
  localparam int unsigned SE0_CYC = (SE0_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IDLE_MIN_MS   = 3;
  localparam int unsigned IDLE_CYC = (IDLE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } udi_bus_s;
endpackage

// file: design/udi_top.sv
// Interrupt logic of a USB full-speed device: cause flags, enable mask,
// status, polarity select and the interrupt request pin.
// Assumes SETUP_DONE, PKT_READY and EP_TX come from same-clock logic;
// SE0_PIN and IDLE_PIN come from the line receiver, asynchronous.
`timescale 1ns/1ps
`default_nettype none
module udi_top #(
  parameter int unsigned IDLE_CYCLES = udi_pkg::IDLE_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       SETUP_DONE,
  input  wire logic [7:0] PKT_READY,
  input  wire logic [2:0] EP_TX,
  input  wire logic       SE0_PIN,
  input  wire logic       IDLE_PIN,
  output logic            SOFT_RESET,
  output logic            IRQ_REQUEST_PIN
);
  localparam int unsigned IW = $clog2(IDLE_CYCLES + 1);
  localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_CYCLES - 1);
  localparam logic [7:0] SE0_LAST = 8'(udi_pkg::SE0_CYC - 1);

  if (IDLE_CYCLES < 2) begin : g_chk
    $error("IDLE_CYCLES must be at least 2");
  end
  // The SE0 counter is eight bits wide and saturates at 8'hff, past the hit
  if (udi_pkg::SE0_CYC < 2 || udi_pkg::SE0_CYC > 254) begin : g_chk_se0
    $error("SE0 cycle count must lie in 2..254");
  end

  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  udi_pkg::udi_bus_s bus;
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // Pin inputs: three flops, level accepted when stages two and three agree
  logic [2:0] se0_s_q;
  logic [2:0] idle_s_q;
  logic       se0_q;
  logic       idle_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      se0_s_q  <= 3'h0;
      idle_s_q <= 3'h0;
    end else begin
      se0_s_q  <= {se0_s_q[1:0], SE0_PIN};
      idle_s_q <= {idle_s_q[1:0], IDLE_PIN};
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      se0_q  <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      if (se0_s_q[1] == se0_s_q[2]) begin
        se0_q <= se0_s_q[2];
      end
      if (idle_s_q[1] == idle_s_q[2]) begin
        idle_q <= idle_s_q[2];
      end
    end
  end

  // Register decode
  logic wr_en;
  logic wr_pol;
  logic wr_ep0;
  logic wr_dev;
  logic wr_sys;
  logic swrst;
  assign wr_en  = bus.wr && (bus.addr == udi_pkg::OFS_ENABLE);
  assign wr_pol = bus.wr && (bus.addr == udi_pkg::OFS_PIN_POLARITY_SELECT);
  assign wr_ep0 = bus.wr && (bus.addr == udi_pkg::OFS_EP0ST);
  assign wr_dev = bus.wr && (bus.addr == udi_pkg::OFS_DEVST);
  assign wr_sys = bus.wr && (bus.addr == udi_pkg::OFS_SYSCTL);
  assign swrst  = wr_sys && bus.wdata[udi_pkg::BIT_SWRST];

  // Software reset is one cycle late so the write itself completes cleanly
  logic sw_rst_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sw_rst_q <= 1'b0;
    end else begin
      sw_rst_q <= swrst;
    end
  end
  assign SOFT_RESET = sw_rst_q;

  // Enable mask and polarity
  logic [7:0] enable_q;
  logic       pol_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= udi_pkg::RST_ENABLE; // [R14]
      pol_q    <= udi_pkg::RST_POL;    // [R03]
    end else if (sw_rst_q) begin
      enable_q <= udi_pkg::RST_ENABLE; // [R14]
      pol_q    <= udi_pkg::RST_POL;    // [R03]
    end else begin
      if (wr_en) begin
        enable_q <= bus.wdata; // [R07]
      end
      if (wr_pol) begin
        pol_q <= bus.wdata[udi_pkg::BIT_POL]; // [R02]
      end
    end
  end

  // Setup-ready flag; a new setup beats a clear in the same cycle
  logic setup_q;
  logic setup_clr;
  assign setup_clr = wr_ep0 && bus.wdata[0]; // [R13]
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= 1'b0;
    end else if (sw_rst_q) begin
      setup_q <= 1'b0;
    end else if (SETUP_DONE) begin
      setup_q <= 1'b1; // [R11]
    end else if (setup_clr) begin
      setup_q <= 1'b0; // [R13]
    end
  end

  // Bus reset: SE0 held for the minimum time raises one event
  logic [7:0] se0_cnt_q;
  logic       busrst_q;
  logic       se0_hit;
  logic       busrst_clr;
  assign se0_hit    = se0_q && (se0_cnt_q == SE0_LAST);
  assign busrst_clr = wr_dev && bus.wdata[udi_pkg::BIT_BUSRST];
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      se0_cnt_q <= 8'h00;
    end else if (!se0_q || sw_rst_q) begin
      se0_cnt_q <= 8'h00;
    end else if (se0_cnt_q != 8'hff) begin
      se0_cnt_q <= se0_cnt_q + 8'h01;
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      busrst_q <= 1'b0;
    end else if (sw_rst_q) begin
      busrst_q <= 1'b0;
    end else if (se0_hit) begin
      busrst_q <= 1'b1; // [R15]
    end else if (busrst_clr) begin
      busrst_q <= 1'b0; // [R15]
    end
  end

  // Suspend: idle count saturates so the event fires once per idle period
  logic [IW-1:0] idle_cnt_q;
  logic          susp_q;
  logic          idle_hit;
  logic          resume;
  logic          idle_prev_q;
  assign idle_hit = idle_q && (idle_cnt_q == IDLE_LAST);
  assign resume   = idle_prev_q && !idle_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q  <= '0;
      idle_prev_q <= 1'b0;
    end else begin
      idle_prev_q <= idle_q;
      if (!idle_q || sw_rst_q) begin
        idle_cnt_q <= '0;
      end else if (idle_cnt_q != IDLE_LAST + IW'(1)) begin
        idle_cnt_q <= idle_cnt_q + IW'(1);
      end
    end
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      susp_q <= 1'b0;
    end else if (sw_rst_q) begin
      susp_q <= 1'b0;
    end else if (idle_hit) begin
      susp_q <= 1'b1; // [R16]
    end else if (resume || se0_hit) begin
      susp_q <= 1'b0; // [R16]
    end
  end

  // Cause vector in status bit order
  logic [7:0] cause;
  logic       ep1_c;
  logic       ep2_c;
  logic       ep3_c;
  assign ep1_c = EP_TX[0] ? !PKT_READY[udi_pkg::PR_EP1TX] : PKT_READY[udi_pkg::PR_EP1RX];
  assign ep2_c = EP_TX[1] ? !PKT_READY[udi_pkg::PR_EP2TX] : PKT_READY[udi_pkg::PR_EP2RX];
  assign ep3_c = EP_TX[2] && !PKT_READY[udi_pkg::PR_EP3TX];
  assign cause = {ep3_c, susp_q, busrst_q,
                  !PKT_READY[udi_pkg::PR_EP0TX], PKT_READY[udi_pkg::PR_EP0RX],
                  ep2_c, ep1_c, setup_q}; // [R09] [R10]

  // Status is the gated cause, so a disabled bit can never read 1
  logic [7:0] status;
  logic       pending;
  assign status  = cause & enable_q;         // [R06] [R07] [R08] [R12]
  assign pending = |status;                  // [R04] [R17]

  // Level output, held while anything pends; edges need the mask toggle
  logic irq_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b1; // [R03]
    end else if (sw_rst_q) begin
      irq_q <= 1'b1; // [R03]
    end else begin
      irq_q <= pol_q ? pending : !pending; // [R01] [R02] [R17]
    end
  end
  assign IRQ_REQUEST_PIN = irq_q;

  // Read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  logic [7:0] dev_view;
  assign dev_view = {1'b0, susp_q, busrst_q, 5'h00};
  assign rd_mux = (bus.addr == udi_pkg::OFS_ENABLE) ? enable_q :
                  (bus.addr == udi_pkg::OFS_STATUS) ? status :
                  (bus.addr == udi_pkg::OFS_PIN_POLARITY_SELECT) ? {7'h00, pol_q} :
                  (bus.addr == udi_pkg::OFS_EP0ST)  ? {7'h00, setup_q} :
                  (bus.addr == udi_pkg::OFS_DEVST)  ? dev_view :
                  (bus.addr == udi_pkg::OFS_PACKET_READY_FLAGS) ? PKT_READY :
                  8'h00;

  logic [7:0] rdata_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= bus.rd ? rd_mux : 8'h00;
    end
  end
  assign RDATA = rdata_q;
endmodule
`default_nettype wire

// file: tb/udi_mcu_model.sv
// Servicing microcontroller: an edge-sensitive interrupt input.
// Assumes the bench passes in the polarity it programmed.
`timescale 1ns/1ps
`default_nettype none
module udi_mcu_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic pol,
  output var  int   edges
);
  logic act_q;
  // A held level is seen once; only a fresh edge counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= 1'b0;
      edges <= 0;
    end else begin
      act_q <= (pin == pol);
      if ((pin == pol) && !act_q) begin
        edges <= edges + 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/udi_top_asserts.sv
// Checker on the udi_top ports: bus writes, soft reset and the request pin.
// Assumes enable and polarity change only through bus writes or soft reset.
`timescale 1ns/1ps
`default_nettype none
module udi_top_asserts (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       SETUP_DONE,
  input wire logic       SOFT_RESET,
  input wire logic       IRQ_REQUEST_PIN
);
  logic [7:0] en_q;
  logic       pol_q;
  // Shadow of the programmed mask and polarity
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N || SOFT_RESET) begin
      en_q  <= 8'h01;
      pol_q <= 1'b0;
    end else if (WR && ADDR == 8'h00) begin
      en_q <= WDATA;
    end else if (WR && ADDR == 8'h02) begin
      pol_q <= WDATA[0];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_reset_idle: assert property ($rose(RST_N) |-> IRQ_REQUEST_PIN ##1 IRQ_REQUEST_PIN)
    else $error("pin active after reset");
  a_soft_pulse: assert property (WR && ADDR == 8'h06 && WDATA[0] |=> SOFT_RESET ##1 !SOFT_RESET)
    else $error("soft reset pulse wrong");
  a_soft_pin: assert property (SOFT_RESET && !SETUP_DONE |=> IRQ_REQUEST_PIN)
    else $error("pin not idle after soft reset");
  a_setup_irq: assert property (SETUP_DONE && en_q[0] && !WR |=> ##1 (IRQ_REQUEST_PIN == pol_q) [*2])
    else $error("setup did not raise pin");
  a_setup_masked: assert property (SETUP_DONE && en_q == 8'h00 && !WR |=> ##1 IRQ_REQUEST_PIN != pol_q)
    else $error("masked setup raised pin");
  a_clear_irq: assert property (WR && ADDR == 8'h03 && WDATA[0] && en_q == 8'h01 && !SETUP_DONE
    |=> ##1 IRQ_REQUEST_PIN != pol_q)
    else $error("pin held after setup clear");
  a_mask_low: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 && !pol_q && !$past(pol_q)
    |-> IRQ_REQUEST_PIN)
    else $error("pin active with mask clear");
  a_pol_high: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 && pol_q && $past(pol_q)
    |-> !IRQ_REQUEST_PIN)
    else $error("pin wrong with high polarity");
endmodule
bind udi_top udi_top_asserts i_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .SETUP_DONE(SETUP_DONE), .SOFT_RESET(SOFT_RESET), .IRQ_REQUEST_PIN(IRQ_REQUEST_PIN));
`default_nettype wire

// file: tb/udi_top_tb.sv
// Testbench of udi_top: corner cases, random causes, mask and polarity, then bus reset, suspend and soft reset.
// Assumes the checker and the MCU model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module udi_top_tb;
  localparam int unsigned IDLE_N = 20;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, setup_done = 1'b0;
  logic        se0_pin = 1'b0, idle_pin = 1'b0, pol = 1'b0, soft_reset, irq;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, pkt_ready = 8'hf0, rdata, st, en;
  logic [2:0]  ep_tx = 3'h0;
  logic [31:0] lfsr = 32'h5ca020b3;
  int          edges, e0, miscompares = 0, tests_run = 0, cycles = 0;
  udi_top #(.IDLE_CYCLES(IDLE_N)) i_dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SETUP_DONE(setup_done), .PKT_READY(pkt_ready), .EP_TX(ep_tx),
    .SE0_PIN(se0_pin), .IDLE_PIN(idle_pin), .SOFT_RESET(soft_reset), .IRQ_REQUEST_PIN(irq));
  udi_mcu_model i_mcu (.clk(clk), .rst_n(rst_n), .pin(irq), .pol(pol), .edges(edges));
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_stat(input logic [7:0] pk, input logic [2:0] tx, input logic [7:0] m);
    logic [7:0] c;
    c = {tx[2] & !pk[7], 2'b00, !pk[4], pk[0], tx[1] ? !pk[6] : pk[2], tx[0] ? !pk[5] : pk[1], 1'b0};
    return c & m;
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(n, rdata, exp);
  endtask
  task automatic pin_chk(input logic act);
    check("pin", {7'h00, irq}, {7'h00, ~(act ^ pol)});
  endtask
  task automatic pulse_setup();
    @(posedge clk);
    setup_done <= 1'b1;
    @(posedge clk);
    setup_done <= 1'b0;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    pin_chk(1'b0);
    rd_chk("enable", 8'h00, 8'h01);
    rd_chk("polarity", 8'h02, 8'h00);
    pulse_setup();
    tick(4);
    pin_chk(1'b1);
    rd_chk("ep0 status", 8'h03, 8'h01);
    rd_chk("status", 8'h01, 8'h01);
    // Second cause while pending: level holds, so no edge until mask is cycled
    e0 = edges;
    @(posedge clk);
    pkt_ready <= 8'hf1;
    bus_write(8'h00, 8'h09);
    tick(2);
    check("edges", edges[7:0], e0[7:0]);
    rd_chk("status", 8'h01, 8'h09);
    bus_write(8'h00, 8'h00);
    bus_write(8'h00, 8'h09);
    tick(2);
    check("edges", edges[7:0], e0[7:0] + 8'h01);
    bus_write(8'h00, 8'h01);
    bus_write(8'h03, 8'h01);
    tick(2);
    pin_chk(1'b0);
    rd_chk("ep0 status", 8'h03, 8'h00);
    bus_write(8'h00, 8'h00);
    pulse_setup();
    tick(3);
    pin_chk(1'b0);
    bus_write(8'h00, 8'h01);
    tick(2);
    pin_chk(1'b1);
    bus_write(8'h03, 8'h01);
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      en = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lfsr[23:16];
      @(posedge clk);
      pkt_ready <= lfsr[7:0];
      ep_tx <= lfsr[10:8];
      bus_write(8'h00, en);
      bus_write(8'h02, {7'h00, (i == 0) | lfsr[24]});
      pol = (i == 0) | lfsr[24];
      tick(2);
      st = exp_stat(lfsr[7:0], lfsr[10:8], en);
      rd_chk("status", 8'h01, st);
      pin_chk(|st);
    end
    @(posedge clk);
    pkt_ready <= 8'hf0;
    ep_tx <= 3'h0;
    bus_write(8'h00, 8'h60);
    @(posedge clk);
    se0_pin <= 1'b1;
    tick(110);
    rd_chk("status", 8'h01, 8'h20);
    rd_chk("dev state", 8'h04, 8'h20);
    se0_pin <= 1'b0;
    bus_write(8'h04, 8'h20);
    tick(2);
    rd_chk("status", 8'h01, 8'h00);
    idle_pin <= 1'b1;
    tick(IDLE_N + 10);
    rd_chk("status", 8'h01, 8'h40);
    idle_pin <= 1'b0;
    tick(6);
    rd_chk("status", 8'h01, 8'h00);
    bus_write(8'h06, 8'h01);
    pol = 1'b0;
    tick(3);
    pin_chk(1'b0);
    rd_chk("enable", 8'h00, 8'h01);
    rd_chk("polarity", 8'h02, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
